/* logic/sivr_regs.v */
// register bank for the synthesizer reference path, pump and calibration
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "sivr_consts.vh"
// What this block does
// - one-bit reference doubler enable, 1 doubles reference, resets to 0
// - five-bit multiplier, 1 bypass, 3..7 multiply, resets to 1
// - eight-bit post-divider ratio after multiplier, resets to 1
// - twelve-bit pre-divider ratio before multiplier, resets to 1
// - three-bit pump current code, reserved 2 and 6, resets to 7
// - amplitude force makes calibration use the forced amplitude, resets to 0
// - nine-bit forced amplitude value, resets to 128
// - nine-bit amplitude search start value, resets to 250
// - band force makes calibration use the forced band, resets to 0
// - eight-bit forced band value, resets to 183
// - three-bit core select names start or forced core, resets to 7
// - core force restricts calibration to the selected core, resets to 0
// - calibration clock divider code 0..3 divides by 1,2,4,8; resets to 3
// - writing 1 to calibration enable starts a frequency calibration
module sivr_regs (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  output reg o_ref_doubler_en,
  output reg [4:0] o_input_multiplier,
  output reg [7:0] o_ref_post_div,
  output reg [11:0] o_ref_pre_div,
  output reg [2:0] o_pump_current_code,
  output reg [7:0] o_amp_cal_compare_delay,
  output reg o_amplitude_force,
  output reg o_band_force,
  output reg [8:0] o_forced_amplitude_value,
  output reg [8:0] o_amplitude_start_value,
  output reg [7:0] o_forced_band_value,
  output reg [2:0] o_core_select,
  output reg o_core_force,
  output reg [1:0] o_cal_clk_div,
  output reg o_freq_cal_start
);

  reg [15:0] amp_cal_delay_cfg;
  reg [15:0] cal_force_ctrl;
  reg [15:0] ref_doubler_cfg;
  reg [15:0] ref_multiplier_cfg;
  reg [15:0] ref_post_divider;
  reg [15:0] ref_pre_divider;
  reg [15:0] pump_current_cfg;
  reg [15:0] forced_amplitude;
  reg [15:0] amplitude_start;
  reg [15:0] forced_band;
  reg [15:0] core_select_cfg;
  reg [15:0] cal_ctrl;
  reg wr_pend;
  reg [5:0] wr_idx;
  reg [15:0] rd_data;
  reg [15:0] next_rd;
  wire [5:0] addr_idx;
  wire take;

  // word index of a byte address, shared by read and write decode
  function [5:0] sivr_idx;
    input [31:0] a;
    begin
      sivr_idx = a[7:2];
    end
  endfunction

  // write strobe for one register word in the data phase
  // shared by every register process and by the start pulse
  function sivr_hit;
    input pend;
    input [5:0] idx;
    input [5:0] want;
    begin
      sivr_hit = pend & (idx == want);
    end
  endfunction

  // transfer size is not decoded: every register is one aligned word,
  // so narrower accesses simply act on the whole word
  assign addr_idx = sivr_idx(i_haddr);
  assign take = i_hsel & i_hready & i_htrans[1];
  // zero wait states, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = {16'h0000, rd_data};

  // read mux; unmapped words read zero
  // the start bit reads back as zero so a read-modify-write
  // of the control word never starts a second calibration
  always @* begin
    case (addr_idx)
      `SIVR_IDX_AMP_DELAY: next_rd = amp_cal_delay_cfg;
      `SIVR_IDX_FORCE: next_rd = cal_force_ctrl;
      `SIVR_IDX_DOUBLER: next_rd = ref_doubler_cfg;
      `SIVR_IDX_INPUT_MULTIPLIER: next_rd = ref_multiplier_cfg;
      `SIVR_IDX_POST_DIV: next_rd = ref_post_divider;
      `SIVR_IDX_PRE_DIV: next_rd = ref_pre_divider;
      `SIVR_IDX_PUMP: next_rd = pump_current_cfg;
      `SIVR_IDX_FAMP: next_rd = forced_amplitude;
      `SIVR_IDX_AMP_START: next_rd = amplitude_start;
      `SIVR_IDX_FBAND: next_rd = forced_band;
      `SIVR_IDX_CORE: next_rd = core_select_cfg;
      `SIVR_IDX_CAL_CTRL: next_rd = {cal_ctrl[15:5], 1'b0, cal_ctrl[3:0]};
      default: next_rd = 16'h0000;
    endcase
  end

  // address phase capture; read data registered for the data phase
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
      rd_data <= 16'h0000;
    end else begin
      wr_pend <= take & i_hwrite;
      wr_idx <= addr_idx;
      if (take & ~i_hwrite) begin
        rd_data <= next_rd;
      end
    end
  end

  // start pulse for one cycle on a write of 1
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_freq_cal_start <= 1'b0;
    end else begin
      o_freq_cal_start <= sivr_hit(wr_pend, wr_idx, `SIVR_IDX_CAL_CTRL) &
                          i_hwdata[`SIVR_CAL_START_BIT];
    end
  end

  // compare delay word; kept until rewritten or reset
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp_cal_delay_cfg <= `SIVR_RST_AMP_DELAY;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_AMP_DELAY)) begin
      amp_cal_delay_cfg <= i_hwdata[15:0];
    end
  end

  // amplitude and band force word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cal_force_ctrl <= `SIVR_RST_FORCE;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_FORCE)) begin
      cal_force_ctrl <= i_hwdata[15:0];
    end
  end

  // doubler word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_doubler_cfg <= `SIVR_RST_DOUBLER;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_DOUBLER)) begin
      ref_doubler_cfg <= i_hwdata[15:0];
    end
  end

  // multiplier word; reserved codes are stored as written
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_multiplier_cfg <= `SIVR_RST_INPUT_MULTIPLIER;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_INPUT_MULTIPLIER)) begin
      ref_multiplier_cfg <= i_hwdata[15:0];
    end
  end

  // post-divider word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_post_divider <= `SIVR_RST_POST_DIV;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_POST_DIV)) begin
      ref_post_divider <= i_hwdata[15:0];
    end
  end

  // pre-divider word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_pre_divider <= `SIVR_RST_PRE_DIV;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_PRE_DIV)) begin
      ref_pre_divider <= i_hwdata[15:0];
    end
  end

  // pump current word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pump_current_cfg <= `SIVR_RST_PUMP;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_PUMP)) begin
      pump_current_cfg <= i_hwdata[15:0];
    end
  end

  // forced amplitude word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      forced_amplitude <= `SIVR_RST_FAMP;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_FAMP)) begin
      forced_amplitude <= i_hwdata[15:0];
    end
  end

  // amplitude search start word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amplitude_start <= `SIVR_RST_AMP_START;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_AMP_START)) begin
      amplitude_start <= i_hwdata[15:0];
    end
  end

  // forced band word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      forced_band <= `SIVR_RST_FBAND;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_FBAND)) begin
      forced_band <= i_hwdata[15:0];
    end
  end

  // core select word
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_select_cfg <= `SIVR_RST_CORE;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_CORE)) begin
      core_select_cfg <= i_hwdata[15:0];
    end
  end

  // calibration control word; the start bit is masked on read
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cal_ctrl <= `SIVR_RST_CAL_CTRL;
    end else if (sivr_hit(wr_pend, wr_idx, `SIVR_IDX_CAL_CTRL)) begin
      cal_ctrl <= i_hwdata[15:0];
    end
  end

  // field outputs; force values latched only when a calibration starts,
  // so mid-calibration writes to the force, start and core words cannot disturb a running search
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ref_doubler_en <= `SIVR_RST_DOUBLER_EN;
      o_input_multiplier <= `SIVR_RST_INPUT_MULTIPLIER_VAL;
      o_ref_post_div <= `SIVR_RST_POST_VAL;
      o_ref_pre_div <= `SIVR_RST_PRE_VAL;
      o_pump_current_code <= `SIVR_RST_PUMP_VAL;
      o_amp_cal_compare_delay <= `SIVR_RST_DELAY_VAL;
      o_cal_clk_div <= `SIVR_RST_CAL_DIV;
      o_amplitude_force <= 1'b0;
      o_band_force <= 1'b0;
      o_forced_amplitude_value <= `SIVR_RST_FAMP_VAL;
      o_amplitude_start_value <= `SIVR_RST_START_VAL;
      o_forced_band_value <= `SIVR_RST_FBAND_VAL;
      o_core_select <= `SIVR_RST_CORE_VAL;
      o_core_force <= 1'b0;
    end else begin
      o_ref_doubler_en <= ref_doubler_cfg[`SIVR_DOUBLER_BIT];
      o_input_multiplier <= ref_multiplier_cfg[11:7];
      o_ref_post_div <= ref_post_divider[11:4];
      o_ref_pre_div <= ref_pre_divider[11:0];
      o_pump_current_code <= pump_current_cfg[6:4];
      o_amp_cal_compare_delay <= amp_cal_delay_cfg[15:8];
      o_cal_clk_div <= cal_ctrl[1:0];
      if (o_freq_cal_start) begin
        o_amplitude_force <= cal_force_ctrl[`SIVR_AMP_FORCE_BIT];
        o_band_force <= cal_force_ctrl[`SIVR_BAND_FORCE_BIT];
        o_forced_amplitude_value <= forced_amplitude[8:0];
        o_amplitude_start_value <= amplitude_start[8:0];
        o_forced_band_value <= forced_band[7:0];
        o_core_select <= core_select_cfg[13:11];
        o_core_force <= core_select_cfg[`SIVR_CORE_FORCE_BIT];
      end
    end
  end

endmodule
`default_nettype wire

/* logic/sivr_consts.vh */
// constants for the synthesizer input, pump and calibration register bank
`ifndef SIVR_CONSTS_VH
`define SIVR_CONSTS_VH
// register indices; byte address is four times the index
`define SIVR_IDX_AMP_DELAY 6'h04
`define SIVR_IDX_FORCE 6'h08
`define SIVR_IDX_DOUBLER 6'h09
`define SIVR_IDX_INPUT_MULTIPLIER 6'h0A
`define SIVR_IDX_POST_DIV 6'h0B
`define SIVR_IDX_PRE_DIV 6'h0C
`define SIVR_IDX_PUMP 6'h0E
`define SIVR_IDX_FAMP 6'h10
`define SIVR_IDX_AMP_START 6'h11
`define SIVR_IDX_FBAND 6'h13
`define SIVR_IDX_CORE 6'h14
`define SIVR_IDX_CAL_CTRL 6'h18
// reset images of whole registers, constant bits included
`define SIVR_RST_AMP_DELAY 16'h0A43
`define SIVR_RST_FORCE 16'h2000
`define SIVR_RST_DOUBLER 16'h0604
`define SIVR_RST_INPUT_MULTIPLIER 16'h10D8
`define SIVR_RST_POST_DIV 16'h0018
`define SIVR_RST_PRE_DIV 16'h5001
`define SIVR_RST_PUMP 16'h1E70
`define SIVR_RST_FAMP 16'h0080
`define SIVR_RST_AMP_START 16'h00FA
`define SIVR_RST_FBAND 16'h27B7
`define SIVR_RST_CORE 16'hF848
`define SIVR_RST_CAL_CTRL 16'h0003
// reset values of the field outputs
`define SIVR_RST_DOUBLER_EN 1'b0
`define SIVR_RST_INPUT_MULTIPLIER_VAL 5'h01
`define SIVR_RST_POST_VAL 8'h01
`define SIVR_RST_PRE_VAL 12'h001
`define SIVR_RST_PUMP_VAL 3'h7
`define SIVR_RST_DELAY_VAL 8'h0A
`define SIVR_RST_CAL_DIV 2'h3
`define SIVR_RST_FAMP_VAL 9'h080
`define SIVR_RST_START_VAL 9'h0FA
`define SIVR_RST_FBAND_VAL 8'hB7
`define SIVR_RST_CORE_VAL 3'h7
// field positions
`define SIVR_DOUBLER_BIT 12
`define SIVR_AMP_FORCE_BIT 14
`define SIVR_BAND_FORCE_BIT 11
`define SIVR_CORE_FORCE_BIT 10
`define SIVR_CAL_START_BIT 4
`endif

/* verif/sivr_regs_sva.sv */
// timing checker for the register bank bus answer, field outputs and start pulse
`timescale 1ns/10ps
`default_nettype none
module sivr_regs_sva (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_ref_doubler_en,
  input wire logic [4:0] o_input_multiplier,
  input wire logic [2:0] o_pump_current_code,
  input wire logic [7:0] o_amp_cal_compare_delay,
  input wire logic [1:0] o_cal_clk_div,
  input wire logic o_amplitude_force,
  input wire logic [2:0] o_core_select,
  input wire logic o_freq_cal_start
);
  logic wr_q;
  logic rd_q;
  logic [31:0] a_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // data-phase tracker; hready never drops, so each taken request has one data cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {wr_q, rd_q, a_q} <= '0;
    end else begin
      wr_q <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
      rd_q <= i_hsel && i_hready && i_htrans[1] && !i_hwrite;
      a_q <= i_haddr;
    end
  end
  // field outputs lag the register by one clock, so two clocks after the data phase
  a_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus answer not ready okay");
  a_doubler_follow: assert property ((wr_q && a_q == 32'h24) |-> ##2
    o_ref_doubler_en == $past(i_hwdata[12], 2)) else $error("doubler enable wrong");
  a_input_multiplier_follow: assert property ((wr_q && a_q == 32'h28) |-> ##2
    o_input_multiplier == $past(i_hwdata[11:7], 2)) else $error("multiplier wrong");
  a_pump_follow: assert property ((wr_q && a_q == 32'h38) |-> ##2
    o_pump_current_code == $past(i_hwdata[6:4], 2)) else $error("pump code wrong");
  a_delay_follow: assert property ((wr_q && a_q == 32'h10) |-> ##2
    o_amp_cal_compare_delay == $past(i_hwdata[15:8], 2)) else $error("delay wrong");
  a_caldiv_follow: assert property ((wr_q && a_q == 32'h60) |-> ##2
    o_cal_clk_div == $past(i_hwdata[1:0], 2)) else $error("cal divider wrong");
  a_start_cause: assert property (o_freq_cal_start ==
    $past(wr_q && a_q == 32'h60 && i_hwdata[4])) else $error("start pulse wrong");
  a_snap_hold: assert property ((!o_freq_cal_start && !$past(o_freq_cal_start)) |->
    $stable({o_amplitude_force, o_core_select})) else $error("forced value moved early");
  a_unmapped_zero: assert property ((rd_q && a_q == 32'h3C) |-> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  c_start: cover property (o_freq_cal_start);
  c_doubler: cover property (wr_q && a_q == 32'h24);
  c_unmapped: cover property (rd_q && a_q == 32'h3C);
endmodule
bind sivr_regs sivr_regs_sva sivr_regs_sva_i (.*);
`default_nettype wire

/* verif/sivr_regs_tb.sv */
// self-checking bench for the reference path, pump and calibration register bank
`timescale 1ns/10ps
`default_nettype none
module sivr_regs_tb;
  logic i_clk = 0, i_reset_n = 0, i_hsel = 0, i_hwrite = 0;
  logic [31:0] i_haddr = '0, i_hwdata = '0;
  logic [1:0] i_htrans = '0;
  logic [2:0] i_hsize = 3'h2;
  wire i_hready, o_hreadyout, o_hresp, o_ref_doubler_en, o_amplitude_force, o_band_force;
  wire o_core_force, o_freq_cal_start;
  wire [31:0] o_hrdata;
  wire [4:0] o_input_multiplier;
  wire [7:0] o_ref_post_div, o_amp_cal_compare_delay, o_forced_band_value;
  wire [11:0] o_ref_pre_div;
  wire [2:0] o_pump_current_code, o_core_select;
  wire [8:0] o_forced_amplitude_value, o_amplitude_start_value;
  wire [1:0] o_cal_clk_div;
  int errors = 0, comparisons = 0;
  logic [31:0] adr [12] = '{'h10, 'h20, 'h24, 'h28, 'h2C, 'h30, 'h38, 'h40, 'h44, 'h4C, 'h50, 'h60};
  logic [15:0] rv [12] = '{'h0A43, 'h2000, 'h0604, 'h10D8, 'h0018, 'h5001, 'h1E70, 'h0080,
    'h00FA, 'h27B7, 'hF848, 'h0003};
  logic [15:0] wv [11] = '{'h1943, 'h6800, 'h1604, 'h13D8, 'h0048, 'h5FFF, 'h1E40, 'h01FF,
    'h0000, 'h27FF, 'hCC48};
  // single slave, so its own ready is the bus ready
  assign i_hready = o_hreadyout;
  sivr_regs sivr_regs_i (.*);
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [71:0] exp, logic [71:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait for ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 50) begin
        errors++;
        report_and_stop();
      end
    end while (o_hreadyout !== 1'b1);
  endtask
  // one single word transfer; read data taken at the edge that ends the data phase
  task automatic xfer(logic w, logic [31:0] a, logic [15:0] d, output logic [31:0] r);
    i_hsel <= 1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= w;
    wait_rdy();
    i_hsel <= 0;
    i_htrans <= 2'h0;
    i_hwdata <= {16'h0, d};
    wait_rdy();
    r = o_hrdata;
  endtask
  task automatic rd(logic [31:0] a, logic [15:0] e);
    logic [31:0] r;
    xfer(0, a, 16'h0, r);
    chk("read", e, r);
  endtask
  task automatic wr(logic [31:0] a, logic [15:0] d);
    logic [31:0] r;
    xfer(1, a, d, r);
  endtask
  task automatic chk_rst();
    for (int k = 0; k < 12; k++) rd(adr[k], rv[k]);
    chk("ref_fields", {1'b0, 5'h01, 8'h01, 12'h001, 3'h7, 8'h0A, 2'h3}, {o_ref_doubler_en,
      o_input_multiplier, o_ref_post_div, o_ref_pre_div, o_pump_current_code,
      o_amp_cal_compare_delay, o_cal_clk_div});
    chk("cal_fields", {2'h0, 9'h080, 9'h0FA, 8'hB7, 3'h7, 1'b0}, {o_amplitude_force,
      o_band_force, o_forced_amplitude_value, o_amplitude_start_value, o_forced_band_value,
      o_core_select, o_core_force});
  endtask
  // reset, single unpipelined writes, calibration start, unmapped place, reset again
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1;
    @(posedge i_clk);
    chk_rst();
    for (int k = 0; k < 11; k++) wr(adr[k], wv[k]);
    for (int k = 0; k < 11; k++) rd(adr[k], wv[k]);
    chk("ref_new", {1'b1, 5'h07, 8'h04, 12'hFFF, 3'h4, 8'h19}, {o_ref_doubler_en,
      o_input_multiplier, o_ref_post_div, o_ref_pre_div, o_pump_current_code,
      o_amp_cal_compare_delay});
    chk("cal_held", {1'b0, 3'h7}, {o_amplitude_force, o_core_select});
    wr(32'h60, 16'h0011);
    // sample away from the edges that launch the pulse
    @(negedge i_clk);
    chk("start", 1'b1, o_freq_cal_start);
    @(negedge i_clk);
    chk("start_end", 1'b0, o_freq_cal_start);
    @(negedge i_clk);
    chk("cal_new", {2'h3, 9'h1FF, 9'h000, 8'hFF, 3'h1, 1'b1}, {o_amplitude_force,
      o_band_force, o_forced_amplitude_value, o_amplitude_start_value, o_forced_band_value,
      o_core_select, o_core_force});
    rd(32'h60, 16'h0001);
    chk("cal_div", 2'h1, o_cal_clk_div);
    wr(32'h3C, 16'hFFFF);
    rd(32'h3C, 16'h0000);
    i_reset_n <= 0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1;
    @(posedge i_clk);
    chk_rst();
    report_and_stop();
  end
endmodule
`default_nettype wire
